/* File: hw/p4cs_consts.svh */
/*
 * Offsets, field positions and reset values of the four-pin
 * chip-select port. Assumes inclusion by bare name from the design file.
 */
`ifndef P4CS_CONSTS_SVH
`define P4CS_CONSTS_SVH

// ==========================================
// special function register addresses
`define P4CS_ADDR_MODE_A 8'h92
`define P4CS_ADDR_MODE_B 8'h93
`define P4CS_ADDR_P0_LO 8'h94
`define P4CS_ADDR_P0_HI 8'h95
`define P4CS_ADDR_P1_LO 8'h96
`define P4CS_ADDR_P1_HI 8'h97
`define P4CS_ADDR_P2_LO 8'h9a
`define P4CS_ADDR_P2_HI 8'h9b
`define P4CS_ADDR_P3_LO 8'h9c
`define P4CS_ADDR_P3_HI 8'h9d
`define P4CS_ADDR_INVERT 8'ha2
`define P4CS_ADDR_DATA 8'ha5

// ==========================================
// field positions
`define P4CS_MASK_LSB 0
`define P4CS_MODE_LSB 2
`define P4CS_INV_LSB 4
`define P4CS_REBOOT_PIN 3

// ==========================================
// reset values
`define P4CS_RST_MODE 8'h00
`define P4CS_RST_MATCH 8'h00
`define P4CS_RST_INVERT 4'h0
`define P4CS_RST_DATA 4'hf
`define P4CS_UNMAPPED 8'hff
`define P4CS_FILL_NIBBLE 4'hf

`endif

/* File: hw/p4cs_pkg.sv */
/*
 * Types of the four-pin chip-select port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package p4cs_pkg;

    // ==========================================
    // pin modes
    typedef enum logic [1:0] {
        P4CS_GPIO,
        P4CS_RD_STROBE,
        P4CS_WR_STROBE,
        P4CS_RW_STROBE
    } p4cs_mode_t;

    // ==========================================
    // per-pin configuration nibble
    typedef struct packed {
        p4cs_mode_t mode;
        logic [1:0] mask;
    } p4cs_cfg_t;

    // ==========================================
    // external data bus access, strobes active low
    typedef struct packed {
        logic [15:0] addr;
        logic rd_n;
        logic wr_n;
    } p4cs_ext_t;

    // ==========================================
    // special function register access
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } p4cs_sfr_t;

endpackage

/* File: hw/p4cs_port.sv */
/*
 * Four-pin multipurpose port: general I/O or address-matched chip-select
 * strobes, per-pin polarity, reboot request from the top pin in gpio mode.
 * Assumes the core presents special function register accesses and the
 * external data bus strobes synchronous to clk.
 */
// Notes on behaviour
// - mode 0: pin is plain GPIO, reset default for all pins
// - mode 1: read strobe on matching reads
// - mode 2: write strobe on matching writes
// - mode 3: strobe on matching read or write
// - per-pin 16-bit comparator from high/low bytes
// - two control registers hold mode and mask
// - low address lines can be masked out
// - per-pin inversion gives positive polarity strobe
// - data writes touch only GPIO pins
// - top pin doubles as hardware reboot input while in gpio mode
// - port data register at address a5
// - unimplemented bits read as one
`timescale 1ns/1ps
`include "p4cs_consts.svh"

module p4cs_port
    import p4cs_pkg::*;
#(
    parameter int PINS = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire p4cs_sfr_t sfr,
    output logic [7:0] sfr_rdata,
    input wire p4cs_ext_t ext,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic reboot_req
);

    // ==========================================
    // elaboration check
    if (PINS != 4) begin : g_pins_check
        $error("p4cs_port serves exactly four pins");
    end

    // ==========================================
    // registers
    logic [7:0] mode_a_q;
    logic [7:0] mode_b_q;
    logic [7:0] match_lo_q [PINS];
    logic [7:0] match_hi_q [PINS];
    logic [PINS-1:0] invert_q;
    logic [PINS-1:0] data_q;
    logic [7:0] rdata_q;
    logic pin3_prev_q;
    logic reboot_q;

    p4cs_cfg_t cfg [PINS];
    logic [PINS-1:0] match;
    logic [PINS-1:0] active;
    logic [PINS-1:0] is_gpio;

    assign cfg[0] = p4cs_cfg_t'(mode_a_q[3:0]);
    assign cfg[1] = p4cs_cfg_t'(mode_a_q[7:4]);
    assign cfg[2] = p4cs_cfg_t'(mode_b_q[3:0]);
    assign cfg[3] = p4cs_cfg_t'(mode_b_q[7:4]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_a_q <= `P4CS_RST_MODE;
            mode_b_q <= `P4CS_RST_MODE;
        end else if (sfr.wr) begin
            if (sfr.addr == `P4CS_ADDR_MODE_A) begin
                mode_a_q <= sfr.wdata;
            end
            if (sfr.addr == `P4CS_ADDR_MODE_B) begin
                mode_b_q <= sfr.wdata;
            end
        end
    end

    function automatic logic [7:0] lo_addr(input int i);
        unique case (i)
            0: lo_addr = `P4CS_ADDR_P0_LO;
            1: lo_addr = `P4CS_ADDR_P1_LO;
            2: lo_addr = `P4CS_ADDR_P2_LO;
            default: lo_addr = `P4CS_ADDR_P3_LO;
        endcase
    endfunction

    function automatic logic [7:0] hi_addr(input int i);
        unique case (i)
            0: hi_addr = `P4CS_ADDR_P0_HI;
            1: hi_addr = `P4CS_ADDR_P1_HI;
            2: hi_addr = `P4CS_ADDR_P2_HI;
            default: hi_addr = `P4CS_ADDR_P3_HI;
        endcase
    endfunction

    // thermometer of ignored low address lines
    function automatic logic [15:0] ignore_bits(input logic [1:0] code);
        unique case (code)
            2'h0: ignore_bits = 16'h0000;
            2'h1: ignore_bits = 16'h0001;
            2'h2: ignore_bits = 16'h0003;
            2'h3: ignore_bits = 16'h0007;
        endcase
    endfunction

    for (genvar g = 0; g < PINS; g++) begin : g_pin
        logic [15:0] cmp;
        logic [15:0] care;

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                match_lo_q[g] <= `P4CS_RST_MATCH;
                match_hi_q[g] <= `P4CS_RST_MATCH;
            end else if (sfr.wr) begin
                if (sfr.addr == lo_addr(g)) begin
                    match_lo_q[g] <= sfr.wdata;
                end
                if (sfr.addr == hi_addr(g)) begin
                    match_hi_q[g] <= sfr.wdata;
                end
            end
        end

        assign cmp = {match_hi_q[g], match_lo_q[g]};
        assign care = ~ignore_bits(cfg[g].mask);
        assign match[g] = ((ext.addr ^ cmp) & care) == 16'h0000;

        always_comb begin
            unique case (cfg[g].mode)
                P4CS_GPIO: active[g] = 1'b0;
                P4CS_RD_STROBE: active[g] = match[g] && !ext.rd_n;
                P4CS_WR_STROBE: active[g] = match[g] && !ext.wr_n;
                P4CS_RW_STROBE: active[g] = match[g] && (!ext.rd_n || !ext.wr_n);
            endcase
        end

        assign is_gpio[g] = cfg[g].mode == P4CS_GPIO;
        // strobes idle high unless inverted; gpio drives low only
        assign pin_out[g] = is_gpio[g] ? data_q[g] : (active[g] ^ ~invert_q[g]);
        assign pin_oe[g] = is_gpio[g] ? !data_q[g] : 1'b1;
    end

    // ==========================================
    // inversion and port data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            invert_q <= `P4CS_RST_INVERT;
        end else if (sfr.wr && sfr.addr == `P4CS_ADDR_INVERT) begin
            invert_q <= sfr.wdata[`P4CS_INV_LSB +: PINS];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_q <= `P4CS_RST_DATA;
        end else if (sfr.wr && sfr.addr == `P4CS_ADDR_DATA) begin
            data_q <= (sfr.wdata[PINS-1:0] & is_gpio) | (data_q & ~is_gpio);
        end
    end

    // ==========================================
    // register read, answered one cycle later
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= `P4CS_UNMAPPED;
        end else if (sfr.rd) begin
            unique case (sfr.addr)
                `P4CS_ADDR_MODE_A: rdata_q <= mode_a_q;
                `P4CS_ADDR_MODE_B: rdata_q <= mode_b_q;
                `P4CS_ADDR_P0_LO: rdata_q <= match_lo_q[0];
                `P4CS_ADDR_P0_HI: rdata_q <= match_hi_q[0];
                `P4CS_ADDR_P1_LO: rdata_q <= match_lo_q[1];
                `P4CS_ADDR_P1_HI: rdata_q <= match_hi_q[1];
                `P4CS_ADDR_P2_LO: rdata_q <= match_lo_q[2];
                `P4CS_ADDR_P2_HI: rdata_q <= match_hi_q[2];
                `P4CS_ADDR_P3_LO: rdata_q <= match_lo_q[3];
                `P4CS_ADDR_P3_HI: rdata_q <= match_hi_q[3];
                `P4CS_ADDR_INVERT: rdata_q <= {invert_q, `P4CS_FILL_NIBBLE};
                `P4CS_ADDR_DATA: rdata_q <= {`P4CS_FILL_NIBBLE, pin_in};
                default: rdata_q <= `P4CS_UNMAPPED;
            endcase
        end
    end

    assign sfr_rdata = rdata_q;

    // ==========================================
    // reboot request on falling top pin while in gpio mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin3_prev_q <= 1'b1;
            reboot_q <= 1'b0;
        end else begin
            pin3_prev_q <= pin_in[`P4CS_REBOOT_PIN];
            reboot_q <= is_gpio[`P4CS_REBOOT_PIN] && pin3_prev_q
                        && !pin_in[`P4CS_REBOOT_PIN];
        end
    end

    assign reboot_req = reboot_q;

    // ==========================================
    // assertions
    sequence data_write_s;
        sfr.wr && sfr.addr == `P4CS_ADDR_DATA;
    endsequence

    sequence data_read_s;
        sfr.rd && sfr.addr == `P4CS_ADDR_DATA;
    endsequence

    sequence pin3_fall_s;
        is_gpio[3] && pin_in[3] ##1 is_gpio[3] && !pin_in[3];
    endsequence

    gpio_default_a: assert property (@(posedge clk)
        $rose(rst_n) |-> pin_out == data_q && pin_oe == ~data_q)
        else $error("pins not gpio after reset");

    rd_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg[2].mode == P4CS_RD_STROBE && match[2] && !ext.rd_n)
        |-> pin_out[2] == invert_q[2] && pin_oe[2])
        else $error("read strobe missing");

    rd_no_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg[2].mode == P4CS_RD_STROBE && ext.rd_n && !ext.wr_n)
        |-> pin_out[2] == !invert_q[2])
        else $error("read strobe on a write");

    wr_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg[2].mode == P4CS_WR_STROBE && ext.rd_n == 1'b0 && ext.wr_n)
        |-> pin_out[2] == !invert_q[2])
        else $error("write strobe on a read");

    wr_active_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg[2].mode == P4CS_WR_STROBE && match[2] && !ext.wr_n)
        |-> pin_out[2] == invert_q[2])
        else $error("write strobe missing");

    inv_active_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg[0].mode == P4CS_WR_STROBE && invert_q[0] && match[0] && !ext.wr_n)
        |-> pin_out[0] && pin_oe[0])
        else $error("inverted strobe not high");

    rw_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg[2].mode == P4CS_RW_STROBE && match[2] && (!ext.rd_n || !ext.wr_n))
        |-> pin_out[2] == invert_q[2])
        else $error("combined strobe missing");

    match_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr.wr && sfr.addr == `P4CS_ADDR_P2_HI) |=> match_hi_q[2] == $past(sfr.wdata))
        else $error("comparator high byte not stored");

    lo_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr.wr && sfr.addr == `P4CS_ADDR_P0_LO) |=> match_lo_q[0] == $past(sfr.wdata))
        else $error("comparator low byte not stored");

    mode_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr.wr && sfr.addr == `P4CS_ADDR_MODE_B) |=> mode_b_q == $past(sfr.wdata))
        else $error("mode byte not stored");

    mask_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg[0].mask == 2'h2 && ext.addr[15:2] == {match_hi_q[0], match_lo_q[0][7:2]})
        |-> match[0])
        else $error("masked range not matched");

    mask_wide_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg[2].mask == 2'h3 && ext.addr[15:3] == {match_hi_q[2], match_lo_q[2][7:3]})
        |-> match[2])
        else $error("eight address range not matched");

    idle_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!is_gpio[2] && !match[2]) |-> pin_out[2] == !invert_q[2])
        else $error("strobe pin not idle");

    gpio_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (data_write_s and is_gpio[1]) |=> data_q[1] == $past(sfr.wdata[1]))
        else $error("gpio pin missed data write");

    data_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
        (data_write_s and is_gpio[3]) |=> pin_oe[3] == !$past(sfr.wdata[3]))
        else $error("gpio pin drive wrong");

    strobe_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (data_write_s and !is_gpio[0]) |=> data_q[0] == $past(data_q[0]))
        else $error("strobe pin took data write");

    data_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        data_read_s |=> sfr_rdata[7:4] == `P4CS_FILL_NIBBLE
        && sfr_rdata[3:0] == $past(pin_in))
        else $error("port read wrong");

    invert_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sfr.rd && sfr.addr == `P4CS_ADDR_INVERT) |=> sfr_rdata[3:0] == `P4CS_FILL_NIBBLE)
        else $error("invert fill bits not one");

    reboot_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        pin3_fall_s |=> reboot_req)
        else $error("reboot not requested");

    reboot_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        reboot_req |=> !reboot_req)
        else $error("reboot request too long");

endmodule

/* File: verif/p4cs_ext_periph.sv */
/*
 * Far side of the four-pin port: board pull-ups on every pin and an
 * external device that can hold any pin low.
 * Assumes pin_oe high while the port drives the pin.
 */
`timescale 1ns/1ps

module p4cs_ext_periph (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pull_low,
    output logic [3:0] pin_in
);
    // ==========================================
    // wired pin level
    // undriven pin floats up, a held-low pin wins over the port
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = (pin_oe[i] ? pin_out[i] : 1'b1) & ~pull_low[i];
        end
    end
endmodule

/* File: verif/tb_p4cs_port.sv */
/*
 * Self-checking bench of the four-pin chip-select port.
 * Assumes the design package, constants header and the pin model.
 */
`timescale 1ns/1ps
`include "p4cs_consts.svh"

module tb_p4cs_port;
    import p4cs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    p4cs_sfr_t sfr = '0;
    p4cs_ext_t ext = '{addr: 16'h0000, rd_n: 1'b1, wr_n: 1'b1};
    logic [3:0] pull_low = 4'h0;
    logic [7:0] sfr_rdata;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic reboot_req;
    int miscompares = 0;
    int checks_done = 0;
    int hits = 0;

    always #12.5 clk = ~clk;

    p4cs_port #(.PINS(4)) dut_u (
        .clk(clk), .rst_n(rst_n), .sfr(sfr), .sfr_rdata(sfr_rdata), .ext(ext),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .reboot_req(reboot_req)
    );
    p4cs_ext_periph periph_u (
        .pin_out(pin_out), .pin_oe(pin_oe), .pull_low(pull_low), .pin_in(pin_in)
    );

    // ==========================================
    // compare and report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================
    // register and external bus access
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr.addr <= a;
        sfr.wdata <= d;
        sfr.wr <= 1'b1;
        @(posedge clk);
        sfr.wr <= 1'b0;
        #1;
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr.addr <= a;
        sfr.rd <= 1'b1;
        @(posedge clk);
        sfr.rd <= 1'b0;
        @(posedge clk);
        #1;
        check(16'(sfr_rdata), 16'(exp));
    endtask

    task automatic ext_acc(input logic [15:0] a, input logic rd, input logic wr);
        @(posedge clk);
        ext.addr <= a;
        ext.rd_n <= ~rd;
        ext.wr_n <= ~wr;
        @(posedge clk);
        #1;
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(16'(pin_out), 16'h000f);
        check(16'(pin_oe), 16'h0000);
        sfr_rd(`P4CS_ADDR_MODE_B, 8'h00);
        sfr_rd(`P4CS_ADDR_P3_HI, 8'h00);
        sfr_rd(`P4CS_ADDR_INVERT, 8'h0f);
        sfr_rd(`P4CS_ADDR_DATA, 8'hff);
        sfr_rd(8'ha3, 8'hff);
        // pin0 write strobe, base 1234, two low lines masked, positive
        sfr_wr(`P4CS_ADDR_P0_HI, 8'h12);
        sfr_wr(`P4CS_ADDR_P0_LO, 8'h34);
        sfr_wr(`P4CS_ADDR_MODE_A, 8'h0a);
        sfr_wr(`P4CS_ADDR_INVERT, 8'h10);
        sfr_rd(`P4CS_ADDR_P0_LO, 8'h34);
        sfr_rd(`P4CS_ADDR_MODE_A, 8'h0a);
        sfr_rd(`P4CS_ADDR_INVERT, 8'h1f);
        for (int i = 0; i < 7; i++) begin
            ext_acc(16'h1232 + 16'(i), 1'b0, 1'b1);
            check(16'(pin_out[0]), 16'(i >= 2 && i <= 5));
        end
        ext_acc(16'h1235, 1'b1, 1'b0);
        check(16'(pin_out[0]), 16'h0000);
        // data writes leave the strobe pin alone
        ext_acc(16'h0000, 1'b0, 1'b0);
        sfr_wr(`P4CS_ADDR_DATA, 8'h00);
        check(16'(pin_oe), 16'h000f);
        check(16'(pin_out), 16'h0000);
        ext_acc(16'h1236, 1'b0, 1'b1);
        check(16'(pin_out), 16'h0001);
        ext_acc(16'h0000, 1'b0, 1'b0);
        sfr_rd(`P4CS_ADDR_DATA, 8'hf0);
        // every strobe mode against every mask width on pin2
        sfr_wr(`P4CS_ADDR_DATA, 8'h0f);
        sfr_wr(`P4CS_ADDR_P2_HI, 8'h56);
        sfr_wr(`P4CS_ADDR_P2_LO, 8'h70);
        for (int m = 1; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                sfr_wr(`P4CS_ADDR_MODE_B, 8'(m * 4 + k));
                for (int op = 1; op < 3; op++) begin
                    ext_acc(16'h5670 + 16'((1 << k) - 1), op[0], op[1]);
                    check(16'(pin_out[2]), 16'(!(m & op)));
                    ext_acc(16'h5670 + 16'(1 << k), op[0], op[1]);
                    check(16'(pin_out[2]), 16'h0001);
                end
            end
        end
        sfr_wr(`P4CS_ADDR_MODE_B, 8'h00);
        ext_acc(16'h5670, 1'b1, 1'b1);
        check(16'(pin_out[2]), 16'h0001);
        check(16'(pin_oe[2]), 16'h0000);
        ext_acc(16'h0000, 1'b0, 1'b0);
        // top pin pulled low from outside asks for a reboot once
        @(posedge clk);
        pull_low <= 4'h8;
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            #1;
            if (reboot_req === 1'b1) begin
                hits++;
            end
        end
        check(16'(hits), 16'h0001);
        final_report();
    end
endmodule
